// ### rtl/sys_wakeup_defines.vh
// Constants for the wakeup timer and brownout control register group
`ifndef SYS_WAKEUP_DEFINES_VH
`define SYS_WAKEUP_DEFINES_VH

// ==========================================================
// Register byte addresses
`define ADDR_ID_HIGH 16'h1806
`define ADDR_ID_LOW 16'h1807
`define ADDR_WAKE_CTRL 16'h1808
`define ADDR_BROWN_CTRL 16'h1809

// ==========================================================
// Identification fields
`define ID_STEP_MSB 7
`define ID_STEP_LSB 4
`define ID_PARTHI_MSB 3
`define ID_PARTHI_LSB 0

// ==========================================================
// Wakeup timer control fields
`define WAKE_FLAG_BIT 7
`define WAKE_CLEAR_BIT 6
`define WAKE_CLKSEL_BIT 5
`define WAKE_IRQEN_BIT 4
`define WAKE_PERIOD_MSB 2
`define WAKE_PERIOD_LSB 0
`define WAKE_PERIOD_OFF 3'h0
`define WAKE_CLKSEL_RESET 1'h0
`define WAKE_IRQEN_RESET 1'h0
`define WAKE_PERIOD_RESET 3'h0

// ==========================================================
// Brownout control and status fields
`define BROWN_FLAG_BIT 7
`define BROWN_CLEAR_BIT 6
`define BROWN_IRQEN_BIT 5
`define BROWN_RSTEN_BIT 4
`define BROWN_STOPEN_BIT 3
`define BROWN_ENABLE_BIT 2
`define BROWN_IRQEN_RESET 1'h0
`define BROWN_RSTEN_RESET 1'h1
`define BROWN_STOPEN_RESET 1'h1
`define BROWN_ENABLE_RESET 1'h1

// ==========================================================
// Wakeup intervals: internal tick period and intervals in ms
`define WAKE_TICK_MS 1
`define WAKE_INT_MS_1 8
`define WAKE_INT_MS_2 32
`define WAKE_INT_MS_3 64
`define WAKE_INT_MS_4 128
`define WAKE_INT_MS_5 256
`define WAKE_INT_MS_6 512
`define WAKE_INT_MS_7 1024
// External source intervals in external clock periods
`define WAKE_EXT_1 256
`define WAKE_EXT_2 1024
`define WAKE_EXT_3 2048
`define WAKE_EXT_4 4096
`define WAKE_EXT_5 8192
`define WAKE_EXT_6 16384
`define WAKE_EXT_7 32768

`endif

// ### rtl/sys_wakeup_brownout_ctrl.v
// Identification, periodic wakeup timer and brownout control registers
`include "sys_wakeup_defines.vh"

// Function
// - Identification byte pair is read only; writes to it change nothing.
// - High id byte: silicon step on top, part number bits 11:8 below; low byte bits 7:0.
// - Wakeup timeout flag in bit 7 sets whenever the wakeup timer expires.
// - Writing 1 to wakeup bit 6 clears the flag; 0 does nothing; reads 0.
// - Wakeup bit 5 selects clock: 0 internal oscillator, 1 external clock.
// - Wakeup bit 4 enables wakeup interrupt requests.
// - Period code zero stops the wakeup timer for either clock source.
// - Internal clock codes 1..7 give 8,32,64,128,256,512,1024 ms.
// - External clock codes 1..7 give 256 up to 32768 external periods.
// - Unused wakeup control bits read zero and ignore writes.
// - With detector enabled, a low supply report sets brownout flag bit 7.
// - Writing 1 to brownout bit 6 clears the flag; that bit reads 0.
// - Brownout bit 5 set raises an interrupt request while the flag is set.
// - Bit 4 with detector enabled makes a set flag force a chip reset.
// - Bit 3 keeps detection running in stop mode; 0 disables it during stop.
// - Bit 2 enables detection; while clear flag, reset, stop bits do nothing.
// - Write-once brownout bits accept only the first write after reset.
// - A brownout reset is reported as the low-voltage reset cause.
module sys_wakeup_brownout_ctrl #(
	parameter [3:0] SILICON_STEP = 4'h1,     // Arbitrary value
	parameter [11:0] PART_NUMBER = 12'h5A3,  // Arbitrary value
	parameter CNT_W = 16
) (
	input wire core_clk,
	input wire reset,
	input wire [15:0] address,
	input wire [7:0] writeData,
	input wire writeStrobe,
	input wire readStrobe,
	output reg [7:0] readData_q,
	input wire internalOsc,
	input wire externalClk,
	input wire lowVoltage,
	input wire stopMode,
	output reg wakeupIrq_q,
	output reg brownoutIrq_q,
	output reg brownoutResetReq_q,
	output reg resetCauseBrownout_q
);

	// ==========================================================
	// Wakeup interval table in source ticks, worked out at full integer width
	localparam integer INT_TICKS_1 = `WAKE_INT_MS_1 / `WAKE_TICK_MS;
	localparam integer INT_TICKS_2 = `WAKE_INT_MS_2 / `WAKE_TICK_MS;
	localparam integer INT_TICKS_3 = `WAKE_INT_MS_3 / `WAKE_TICK_MS;
	localparam integer INT_TICKS_4 = `WAKE_INT_MS_4 / `WAKE_TICK_MS;
	localparam integer INT_TICKS_5 = `WAKE_INT_MS_5 / `WAKE_TICK_MS;
	localparam integer INT_TICKS_6 = `WAKE_INT_MS_6 / `WAKE_TICK_MS;
	localparam integer INT_TICKS_7 = `WAKE_INT_MS_7 / `WAKE_TICK_MS;
	localparam integer EXT_LAST_1 = `WAKE_EXT_1 - 1;
	localparam integer EXT_LAST_2 = `WAKE_EXT_2 - 1;
	localparam integer EXT_LAST_3 = `WAKE_EXT_3 - 1;
	localparam integer EXT_LAST_4 = `WAKE_EXT_4 - 1;
	localparam integer EXT_LAST_5 = `WAKE_EXT_5 - 1;
	localparam integer EXT_LAST_6 = `WAKE_EXT_6 - 1;
	localparam integer EXT_LAST_7 = `WAKE_EXT_7 - 1;
	// Cut to the counter width on purpose; every entry fits in CNT_W bits
	localparam [CNT_W-1:0] INT_1 = INT_TICKS_1[CNT_W-1:0];
	localparam [CNT_W-1:0] INT_2 = INT_TICKS_2[CNT_W-1:0];
	localparam [CNT_W-1:0] INT_3 = INT_TICKS_3[CNT_W-1:0];
	localparam [CNT_W-1:0] INT_4 = INT_TICKS_4[CNT_W-1:0];
	localparam [CNT_W-1:0] INT_5 = INT_TICKS_5[CNT_W-1:0];
	localparam [CNT_W-1:0] INT_6 = INT_TICKS_6[CNT_W-1:0];
	localparam [CNT_W-1:0] INT_7 = INT_TICKS_7[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_1 = EXT_LAST_1[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_2 = EXT_LAST_2[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_3 = EXT_LAST_3[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_4 = EXT_LAST_4[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_5 = EXT_LAST_5[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_6 = EXT_LAST_6[CNT_W-1:0];
	localparam [CNT_W-1:0] EXT_7 = EXT_LAST_7[CNT_W-1:0];
	localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	// ==========================================================
	// Declarations
	reg [2:0] intOscSync_q;
	reg [2:0] extClkSync_q;
	reg [1:0] lowSync_q;
	reg wakeFlag_q;
	reg wakeFlag_d;
	reg wakeClkSel_q;
	reg wakeIrqEn_q;
	reg [2:0] wakePeriod_q;
	reg [CNT_W-1:0] wakeCount_q;
	reg [CNT_W-1:0] wakeCount_d;
	reg [CNT_W-1:0] wakeLast;
	reg brownFlag_q;
	reg brownFlag_d;
	reg brownIrqEn_q;
	reg brownRstEn_q;
	reg brownStopEn_q;
	reg brownEnable_q;
	reg brownLocked_q;
	reg [7:0] readData_d;
	wire wrWake;
	wire wrBrown;
	wire intTick;
	wire extTick;
	wire srcTick;
	wire wakeRestart;
	wire wakeExpire;
	wire detectActive;
	wire wakeClearReq;
	wire brownClearReq;
	wire wakeIrqEn_d;
	wire brownIrqEn_d;
	wire brownRstEn_d;
	wire brownEnable_d;
	wire brownOpenWr;

	// ==========================================================
	// Address decode of the write strobe
	assign wrWake = writeStrobe && (address == `ADDR_WAKE_CTRL);
	assign wrBrown = writeStrobe && (address == `ADDR_BROWN_CTRL);
	assign wakeClearReq = wrWake && writeData[`WAKE_CLEAR_BIT];
	assign brownClearReq = wrBrown && writeData[`BROWN_CLEAR_BIT];

	// Next enable values, so a request follows the bit in the edge that writes it
	assign wakeIrqEn_d = wrWake ? writeData[`WAKE_IRQEN_BIT] : wakeIrqEn_q;
	assign brownIrqEn_d = wrBrown ? writeData[`BROWN_IRQEN_BIT] : brownIrqEn_q;
	// Only the first brownout write after reset reaches the write-once bits
	assign brownOpenWr = wrBrown && !brownLocked_q;
	assign brownRstEn_d = brownOpenWr ? writeData[`BROWN_RSTEN_BIT] : brownRstEn_q;
	assign brownEnable_d = brownOpenWr ? writeData[`BROWN_ENABLE_BIT] : brownEnable_q;

	// ==========================================================
	// Input synchronisers; stage 0 is read only by stage 1
	always @(posedge core_clk) begin
		if (reset) begin
			intOscSync_q <= 3'h0;
			extClkSync_q <= 3'h0;
			lowSync_q <= 2'h0;
		end else begin
			intOscSync_q <= {intOscSync_q[1:0], internalOsc};
			extClkSync_q <= {extClkSync_q[1:0], externalClk};
			lowSync_q <= {lowSync_q[0], lowVoltage};
		end
	end

	// Rising edges taken from the second and third stages
	assign intTick = intOscSync_q[1] && !intOscSync_q[2];
	assign extTick = extClkSync_q[1] && !extClkSync_q[2];
	assign srcTick = wakeClkSel_q ? extTick : intTick;

	// ==========================================================
	// Wakeup control fields; unused bit 3 and clear bit 6 hold no state
	always @(posedge core_clk) begin
		if (reset) begin
			wakeClkSel_q <= `WAKE_CLKSEL_RESET;
			wakeIrqEn_q <= `WAKE_IRQEN_RESET;
			wakePeriod_q <= `WAKE_PERIOD_RESET;
		end else if (wrWake) begin
			wakeClkSel_q <= writeData[`WAKE_CLKSEL_BIT];
			wakeIrqEn_q <= writeData[`WAKE_IRQEN_BIT];
			wakePeriod_q <= writeData[`WAKE_PERIOD_MSB:`WAKE_PERIOD_LSB];
		end
	end

	// A new period or clock source restarts the count
	assign wakeRestart = wrWake &&
		((writeData[`WAKE_PERIOD_MSB:`WAKE_PERIOD_LSB] != wakePeriod_q) ||
		(writeData[`WAKE_CLKSEL_BIT] != wakeClkSel_q));

	// ==========================================================
	// Terminal count for the selected source and period
	always @* begin
		wakeLast = {CNT_W{1'b0}};
		if (wakeClkSel_q) begin
			case (wakePeriod_q)
				3'h1: wakeLast = EXT_1;
				3'h2: wakeLast = EXT_2;
				3'h3: wakeLast = EXT_3;
				3'h4: wakeLast = EXT_4;
				3'h5: wakeLast = EXT_5;
				3'h6: wakeLast = EXT_6;
				3'h7: wakeLast = EXT_7;
				default: wakeLast = {CNT_W{1'b0}};
			endcase
		end else begin
			case (wakePeriod_q)
				3'h1: wakeLast = INT_1 - ONE;
				3'h2: wakeLast = INT_2 - ONE;
				3'h3: wakeLast = INT_3 - ONE;
				3'h4: wakeLast = INT_4 - ONE;
				3'h5: wakeLast = INT_5 - ONE;
				3'h6: wakeLast = INT_6 - ONE;
				3'h7: wakeLast = INT_7 - ONE;
				default: wakeLast = {CNT_W{1'b0}};
			endcase
		end
	end

	// Expiry on the tick that completes the interval
	assign wakeExpire = (wakePeriod_q != `WAKE_PERIOD_OFF) && srcTick &&
		(wakeCount_q == wakeLast) && !wakeRestart;

	// ==========================================================
	// Wakeup tick counter
	always @* begin
		wakeCount_d = wakeCount_q;
		if (wakeRestart || (wakePeriod_q == `WAKE_PERIOD_OFF)) begin
			wakeCount_d = {CNT_W{1'b0}};
		end else if (wakeExpire) begin
			wakeCount_d = {CNT_W{1'b0}};
		end else if (srcTick) begin
			wakeCount_d = wakeCount_q + ONE;
		end
	end

	// Timeout flag: a set in the clearing cycle wins
	always @* begin
		wakeFlag_d = wakeFlag_q;
		if (wakeClearReq) begin
			wakeFlag_d = 1'b0;
		end
		if (wakeExpire) begin
			wakeFlag_d = 1'b1;
		end
	end

	// Wakeup state registers
	always @(posedge core_clk) begin
		if (reset) begin
			wakeCount_q <= {CNT_W{1'b0}};
			wakeFlag_q <= 1'b0;
		end else begin
			wakeCount_q <= wakeCount_d;
			wakeFlag_q <= wakeFlag_d;
		end
	end

	// ==========================================================
	// Brownout controls; enable, reset and stop bits lock after one write
	always @(posedge core_clk) begin
		if (reset) begin
			brownIrqEn_q <= `BROWN_IRQEN_RESET;
			brownRstEn_q <= `BROWN_RSTEN_RESET;
			brownStopEn_q <= `BROWN_STOPEN_RESET;
			brownEnable_q <= `BROWN_ENABLE_RESET;
			brownLocked_q <= 1'b0;
		end else if (wrBrown) begin
			brownIrqEn_q <= writeData[`BROWN_IRQEN_BIT];
			brownLocked_q <= 1'b1;
			if (!brownLocked_q) begin
				brownRstEn_q <= writeData[`BROWN_RSTEN_BIT];
				brownStopEn_q <= writeData[`BROWN_STOPEN_BIT];
				brownEnable_q <= writeData[`BROWN_ENABLE_BIT];
			end
		end
	end

	// Detection runs when enabled, and in stop only if allowed
	assign detectActive = brownEnable_q &&
		(!stopMode || brownStopEn_q);

	// ==========================================================
	// Brownout flag: a set in the clearing cycle wins
	always @* begin
		brownFlag_d = brownFlag_q;
		if (brownClearReq) begin
			brownFlag_d = 1'b0;
		end
		if (detectActive && lowSync_q[1]) begin
			brownFlag_d = 1'b1;
		end
	end

	// Brownout flag register
	always @(posedge core_clk) begin
		if (reset) begin
			brownFlag_q <= 1'b0;
		end else begin
			brownFlag_q <= brownFlag_d;
		end
	end

	// ==========================================================
	// Request outputs from next flag and enable values, so none lags a register write
	always @(posedge core_clk) begin
		if (reset) begin
			wakeupIrq_q <= 1'b0;
			brownoutIrq_q <= 1'b0;
			brownoutResetReq_q <= 1'b0;
			resetCauseBrownout_q <= 1'b0;
		end else begin
			wakeupIrq_q <= wakeFlag_d && wakeIrqEn_d;
			brownoutIrq_q <= brownFlag_d && brownIrqEn_d;
			brownoutResetReq_q <= brownFlag_d && brownEnable_d &&
				brownRstEn_d;
			resetCauseBrownout_q <= brownFlag_d && brownEnable_d &&
				brownRstEn_d;
		end
	end

	// ==========================================================
	// Read multiplexer; write-only and unused bits read zero
	always @* begin
		readData_d = 8'h00;
		case (address)
			`ADDR_ID_HIGH: begin
				readData_d = {SILICON_STEP, PART_NUMBER[11:8]};
			end
			`ADDR_ID_LOW: begin
				readData_d = PART_NUMBER[7:0];
			end
			`ADDR_WAKE_CTRL: begin
				readData_d[`WAKE_FLAG_BIT] = wakeFlag_q;
				readData_d[`WAKE_CLKSEL_BIT] = wakeClkSel_q;
				readData_d[`WAKE_IRQEN_BIT] = wakeIrqEn_q;
				readData_d[`WAKE_PERIOD_MSB:`WAKE_PERIOD_LSB] = wakePeriod_q;
			end
			`ADDR_BROWN_CTRL: begin
				readData_d[`BROWN_FLAG_BIT] = brownFlag_q;
				readData_d[`BROWN_IRQEN_BIT] = brownIrqEn_q;
				readData_d[`BROWN_RSTEN_BIT] = brownRstEn_q;
				readData_d[`BROWN_STOPEN_BIT] = brownStopEn_q;
				readData_d[`BROWN_ENABLE_BIT] = brownEnable_q;
			end
			default: begin
				readData_d = 8'h00;
			end
		endcase
	end

	// Read data stands only in the cycle after the read strobe
	always @(posedge core_clk) begin
		if (reset) begin
			readData_q <= 8'h00;
		end else if (readStrobe) begin
			readData_q <= readData_d;
		end else begin
			readData_q <= 8'h00;
		end
	end

endmodule

// ### verif/sys_wakeup_brownout_props.sv
// Concurrent checks on the wakeup timer and brownout register group ports
`include "sys_wakeup_defines.vh"
module sys_wakeup_brownout_props #(
	parameter [3:0] SILICON_STEP = 4'h1,
	parameter [11:0] PART_NUMBER = 12'h5A3
) (
	input wire core_clk,
	input wire reset,
	input wire [15:0] address,
	input wire [7:0] writeData,
	input wire writeStrobe,
	input wire readStrobe,
	input wire [7:0] readData_q,
	input wire lowVoltage,
	input wire wakeupIrq_q,
	input wire brownoutIrq_q,
	input wire brownoutResetReq_q,
	input wire resetCauseBrownout_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// ==========================================================
	// Bus access sequences
	sequence rdAt(logic [15:0] a);
		readStrobe && address == a;
	endsequence
	sequence wrWake;
		writeStrobe && address == `ADDR_WAKE_CTRL;
	endsequence

	// ==========================================================
	// Read values
	AST_ID_HIGH: assert property (rdAt(`ADDR_ID_HIGH) |=> readData_q == {SILICON_STEP, PART_NUMBER[11:8]})
		else $error("id high byte wrong");
	AST_ID_LOW: assert property (rdAt(`ADDR_ID_LOW) |=> readData_q == PART_NUMBER[7:0])
		else $error("id low byte wrong");
	AST_WAKE_READ_ZERO: assert property (rdAt(`ADDR_WAKE_CTRL) |=>
		readData_q[6] == 1'b0 && readData_q[3] == 1'b0)
		else $error("wakeup clear or unused bit reads one");
	AST_BROWN_READ_ZERO: assert property (rdAt(`ADDR_BROWN_CTRL) |=> readData_q[6] == 1'b0)
		else $error("brownout clear bit reads one");

	// ==========================================================
	// Interrupt and reset outputs
	AST_WAKE_IRQ_CLEAR: assert property (wrWake ##0 writeData[6] |=> !wakeupIrq_q)
		else $error("wakeup irq stays after clear");
	AST_WAKE_IRQ_DISABLE: assert property (wrWake ##0 !writeData[4] |=> !wakeupIrq_q)
		else $error("wakeup irq while disabled");
	AST_WAKE_PERIOD_OFF: assert property (wrWake ##0 (writeData[6] && writeData[2:0] == 3'h0) |=>
		!wakeupIrq_q [*8])
		else $error("wakeup irq with timer off");
	AST_BROWN_IRQ_DISABLE: assert property (writeStrobe && address == `ADDR_BROWN_CTRL && !writeData[5] |=>
		!brownoutIrq_q)
		else $error("brownout irq while disabled");
	AST_RESET_CAUSE: assert property (resetCauseBrownout_q == brownoutResetReq_q)
		else $error("reset cause differs from reset request");
	AST_BROWN_NEEDS_LOW: assert property ((($rose(brownoutIrq_q) && !$past(writeStrobe)) ||
		$rose(brownoutResetReq_q)) |-> $past(lowVoltage, 3))
		else $error("brownout event without low supply");
endmodule

bind sys_wakeup_brownout_ctrl sys_wakeup_brownout_props #(.SILICON_STEP(SILICON_STEP), .PART_NUMBER(PART_NUMBER))
	i_props (
	.core_clk(core_clk), .reset(reset), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
	.readStrobe(readStrobe), .readData_q(readData_q), .lowVoltage(lowVoltage), .wakeupIrq_q(wakeupIrq_q),
	.brownoutIrq_q(brownoutIrq_q), .brownoutResetReq_q(brownoutResetReq_q), .resetCauseBrownout_q(resetCauseBrownout_q));

// ### verif/sys_wakeup_brownout_ctrl_test.sv
// Self-checking bench for the wakeup timer and brownout register group
`include "sys_wakeup_defines.vh"
module sys_wakeup_brownout_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam [3:0] STEP = 4'h3; // Arbitrary value
	localparam [11:0] PART = 12'h4C7; // Arbitrary value
	logic core_clk = 1'b0, reset = 1'b1, writeStrobe = 1'b0, readStrobe = 1'b0;
	logic internalOsc = 1'b0, externalClk = 1'b0, lowVoltage = 1'b0, stopMode = 1'b0;
	logic [15:0] address = 16'h0000;
	logic [7:0] writeData = 8'h00;
	wire [7:0] readData_q;
	wire wakeupIrq_q, brownoutIrq_q, brownoutResetReq_q, resetCauseBrownout_q;
	int n_mismatch = 0, check_count = 0;
	logic [7:0] wakeCtrl [9] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h31, 8'h32};
	int wakeEdges [9] = '{8, 32, 64, 128, 256, 512, 1024, 256, 1024};

	// Clock at 40 MHz
	always #12.5 core_clk = ~core_clk;

	sys_wakeup_brownout_ctrl #(.SILICON_STEP(STEP), .PART_NUMBER(PART)) i_dut (
		.core_clk(core_clk), .reset(reset), .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
		.readStrobe(readStrobe), .readData_q(readData_q), .internalOsc(internalOsc), .externalClk(externalClk),
		.lowVoltage(lowVoltage), .stopMode(stopMode), .wakeupIrq_q(wakeupIrq_q), .brownoutIrq_q(brownoutIrq_q),
		.brownoutResetReq_q(brownoutResetReq_q), .resetCauseBrownout_q(resetCauseBrownout_q));

	// ==========================================================
	// Tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge core_clk);
		writeStrobe <= 1'b0;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge core_clk);
		readStrobe <= 1'b0;
		#1;
		check(readData_q, exp);
	endtask
	// Rising edges on one wakeup source, four core cycles apart
	task automatic pulse(input logic ext, input int n);
		repeat (n) begin
			@(posedge core_clk);
			externalClk <= ext;
			internalOsc <= ~ext;
			repeat (2) @(posedge core_clk);
			externalClk <= 1'b0;
			internalOsc <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	// Bounded wait: 0 wakeup irq, 1 brownout irq, 2 brownout reset
	task automatic waitSig(input int sel);
		logic [2:0] s;
		for (int i = 0; i < 20; i++) begin
			@(posedge core_clk);
			#1 s = {brownoutResetReq_q, brownoutIrq_q, wakeupIrq_q};
			if (s[sel] === 1'b1) return;
		end
		check(8'h00, 8'h01);
		final_report();
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rdchk(`ADDR_ID_HIGH, {STEP, PART[11:8]});
		rdchk(`ADDR_ID_LOW, PART[7:0]);
		wr(`ADDR_ID_HIGH, 8'hFF);
		wr(`ADDR_ID_LOW, 8'h00);
		rdchk(`ADDR_ID_HIGH, {STEP, PART[11:8]});
		rdchk(`ADDR_ID_LOW, PART[7:0]);
		rdchk(16'h180A, 8'h00);
		rdchk(`ADDR_BROWN_CTRL, 8'h1C);
		wr(`ADDR_WAKE_CTRL, 8'hC8);
		rdchk(`ADDR_WAKE_CTRL, 8'h00);
		$display("test identification done");
		// Period codes 1 to 7 on the internal source, codes 1 and 2 on the external; the other source must not count
		for (int k = 0; k < 9; k++) begin
			wr(`ADDR_WAKE_CTRL, wakeCtrl[k]);
			pulse(wakeCtrl[k][5], wakeEdges[k] - 1);
			pulse(~wakeCtrl[k][5], 4);
			cycles(6);
			check({7'h00, wakeupIrq_q}, 8'h00);
			pulse(wakeCtrl[k][5], 1);
			waitSig(0);
			rdchk(`ADDR_WAKE_CTRL, wakeCtrl[k] | 8'h80);
			wr(`ADDR_WAKE_CTRL, wakeCtrl[k] | 8'h40);
			cycles(1);
			check({7'h00, wakeupIrq_q}, 8'h00);
		end
		wr(`ADDR_WAKE_CTRL, 8'h11);
		pulse(1'b0, 6);
		wr(`ADDR_WAKE_CTRL, 8'h31);
		wr(`ADDR_WAKE_CTRL, 8'h11);
		pulse(1'b0, 6);
		cycles(6);
		check({7'h00, wakeupIrq_q}, 8'h00);
		wr(`ADDR_WAKE_CTRL, 8'h50);
		pulse(1'b0, 40);
		rdchk(`ADDR_WAKE_CTRL, 8'h10);
		wr(`ADDR_WAKE_CTRL, 8'h01);
		pulse(1'b0, 8);
		cycles(6);
		check({7'h00, wakeupIrq_q}, 8'h00);
		rdchk(`ADDR_WAKE_CTRL, 8'h81);
		wr(`ADDR_WAKE_CTRL, 8'h01);
		rdchk(`ADDR_WAKE_CTRL, 8'h81);
		wr(`ADDR_WAKE_CTRL, 8'h41);
		rdchk(`ADDR_WAKE_CTRL, 8'h01);
		$display("test wakeup timer done");
		// Brownout: locked bits, stop mode, flag and clear
		wr(`ADDR_BROWN_CTRL, 8'h24);
		wr(`ADDR_BROWN_CTRL, 8'h18);
		rdchk(`ADDR_BROWN_CTRL, 8'h04);
		wr(`ADDR_BROWN_CTRL, 8'h20);
		stopMode <= 1'b1;
		lowVoltage <= 1'b1;
		cycles(10);
		rdchk(`ADDR_BROWN_CTRL, 8'h24);
		@(posedge core_clk);
		stopMode <= 1'b0;
		waitSig(1);
		rdchk(`ADDR_BROWN_CTRL, 8'hA4);
		check({7'h00, brownoutResetReq_q}, 8'h00);
		@(posedge core_clk);
		lowVoltage <= 1'b0;
		cycles(4);
		wr(`ADDR_BROWN_CTRL, 8'h60);
		rdchk(`ADDR_BROWN_CTRL, 8'h24);
		check({7'h00, brownoutIrq_q}, 8'h00);
		$display("test brownout flag done");
		// Defaults after a second reset force a chip reset request
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		lowVoltage <= 1'b1;
		waitSig(2);
		check({7'h00, resetCauseBrownout_q}, 8'h01);
		check({7'h00, brownoutIrq_q}, 8'h00);
		@(posedge core_clk);
		reset <= 1'b1;
		lowVoltage <= 1'b0;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		wr(`ADDR_BROWN_CTRL, 8'h10);
		lowVoltage <= 1'b1;
		cycles(10);
		check({7'h00, brownoutResetReq_q}, 8'h00);
		rdchk(`ADDR_BROWN_CTRL, 8'h10);
		$display("test brownout reset done");
		final_report();
	end
endmodule
